/* File: hdl/imfb_bank.sv */
// Interrupt mask and factor-flag bank with Wishbone slave and entry timer
// Behaviour
// (RULE_01) Timer mask bits at 0EBH: D2 slow, D1 mid, D0 fast; one enables.
// (RULE_02) Converter mask bit at 0ECH D0; one enables, zero masks.
// (RULE_03) Four per-pin mask bits at 0E8H, one per input pin.
// (RULE_04) Read-only pin pending flag at 0EDH D0, set by pin event.
// (RULE_05) Read-only timer pending flags at 0EFH: D2 slow, D1 mid, D0 fast.
// (RULE_06) Read-only converter done flag at 0F0H D0.
// (RULE_07) Each pending flag clears right after its register is read.
// (RULE_08) Unused bits read zero and ignore writes.
// (RULE_09) Reset clears every mask bit and every pending flag.
// (RULE_10) Interrupt only when flag set, mask set and CPU enable set.
// (RULE_11) Interrupt entry takes twelve system clock cycles.
// (RULE_12) Request is OR of each flag ANDed with its mask.
`timescale 1ns/10ps
`default_nettype none
module imfb_bank (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Event sources
  input wire logic [3:0] input_pins,
  input wire logic slow_tick_event,
  input wire logic mid_tick_event,
  input wire logic fast_tick_event,
  input wire logic converter_done_event,
  // CPU side
  output logic irq_request,
  output logic entry_busy,
  output logic entry_done
);
  typedef struct packed {
    logic [3:0] pin_en;
    logic [2:0] tick_en;
    logic conv_en;
    logic pin_flag;
    logic [2:0] tick_flag;
    logic conv_flag;
    logic ei;
    logic [3:0] entry_cnt;
    logic busy;
    logic done;
    logic ack;
    logic [31:0] rdata;
  } imfb_bank_s;
  imfb_bank_s st_q;
  imfb_bank_s st_d;

  logic [3:0] pin_rise;
  logic access;
  logic rd;
  logic wr;
  logic [2:0] tick_ev;
  logic pend;

  // Pins come from outside, so synchronise before edge detection
  imfb_sync #(.WIDTH(4)) u_pin_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .async_in(input_pins),
    .level_out(),
    .rise_out(pin_rise)
  );

  assign access = wb_cyc_i & wb_stb_i & ~st_q.ack;
  assign rd = access & ~wb_we_i;
  assign wr = access & wb_we_i & wb_sel_i[0];
  assign tick_ev = {slow_tick_event, mid_tick_event, fast_tick_event};

  // (RULE_12) Masked flag OR
  assign pend = (st_q.pin_flag & (|st_q.pin_en)) | (|(st_q.tick_flag & st_q.tick_en))
    | (st_q.conv_flag & st_q.conv_en);

  always_comb
  begin
    st_d = st_q;
    st_d.ack = access;
    st_d.done = 1'b0;
    // (RULE_04) Pin event capture
    if (|(pin_rise & st_q.pin_en))
    begin
      st_d.pin_flag = 1'b1;
    end
    // (RULE_08) Unused bits zero
    st_d.rdata = 32'h0000_0000;
    if (rd)
    begin
      case (wb_adr_i)
        imfb_pkg::IMFB_PIN_EN_ADDR: st_d.rdata[3:0] = st_q.pin_en;
        imfb_pkg::IMFB_TICK_EN_ADDR: st_d.rdata[2:0] = st_q.tick_en;
        imfb_pkg::IMFB_CONV_EN_ADDR: st_d.rdata[imfb_pkg::IMFB_FLAG_BIT] = st_q.conv_en;
        imfb_pkg::IMFB_PIN_FLAG_ADDR: st_d.rdata[imfb_pkg::IMFB_FLAG_BIT] = st_q.pin_flag;
        imfb_pkg::IMFB_TICK_FLAG_ADDR: st_d.rdata[2:0] = st_q.tick_flag;
        imfb_pkg::IMFB_CONV_FLAG_ADDR: st_d.rdata[imfb_pkg::IMFB_FLAG_BIT] = st_q.conv_flag;
        imfb_pkg::IMFB_CTRL_ADDR: st_d.rdata[imfb_pkg::IMFB_EI_BIT] = st_q.ei;
        imfb_pkg::IMFB_ENTRY_ADDR: st_d.rdata[4:0] = {st_q.busy, st_q.entry_cnt};
        default: st_d.rdata = 32'h0000_0000;
      endcase
      // (RULE_07) Clear on read; a same-cycle event wins below
      case (wb_adr_i)
        imfb_pkg::IMFB_PIN_FLAG_ADDR: st_d.pin_flag = |(pin_rise & st_q.pin_en);
        imfb_pkg::IMFB_TICK_FLAG_ADDR: st_d.tick_flag = 3'h0;
        imfb_pkg::IMFB_CONV_FLAG_ADDR: st_d.conv_flag = 1'b0;
        default: st_d.pin_flag = st_d.pin_flag;
      endcase
    end
    // (RULE_05) Timer flags set, set beats clear
    st_d.tick_flag = st_d.tick_flag | tick_ev;
    // (RULE_06) Converter flag set
    st_d.conv_flag = st_d.conv_flag | converter_done_event;
    if (wr)
    begin
      case (wb_adr_i)
        // (RULE_03) Per-pin masks
        imfb_pkg::IMFB_PIN_EN_ADDR: st_d.pin_en = wb_dat_i[3:0];
        // (RULE_01) Timer masks
        imfb_pkg::IMFB_TICK_EN_ADDR: st_d.tick_en = wb_dat_i[2:0];
        // (RULE_02) Converter mask
        imfb_pkg::IMFB_CONV_EN_ADDR: st_d.conv_en = wb_dat_i[imfb_pkg::IMFB_FLAG_BIT];
        imfb_pkg::IMFB_CTRL_ADDR: st_d.ei = wb_dat_i[imfb_pkg::IMFB_EI_BIT];
        default: st_d.ei = st_d.ei;
      endcase
    end
    // (RULE_10) Entry only with CPU enable; enable drops on entry
    if (pend && st_q.ei && !st_q.busy)
    begin
      st_d.ei = 1'b0;
      st_d.busy = 1'b1;
      st_d.entry_cnt = 4'h0;
    end
    // (RULE_11) Twelve-cycle entry
    else if (st_q.busy)
    begin
      if (st_q.entry_cnt == 4'(imfb_pkg::IMFB_ENTRY_CYCLES - 1))
      begin
        st_d.busy = 1'b0;
        st_d.done = 1'b1;
      end
      else
      begin
        st_d.entry_cnt = st_q.entry_cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    // (RULE_09) Reset clears masks and flags
    if (reset)
    begin
      st_q <= '0;
      st_q.pin_en <= imfb_pkg::IMFB_PIN_EN_RST;
      st_q.tick_en <= imfb_pkg::IMFB_TICK_EN_RST;
      st_q.conv_en <= imfb_pkg::IMFB_CONV_EN_RST;
      st_q.tick_flag <= imfb_pkg::IMFB_TICK_FLAG_RST;
      st_q.pin_flag <= imfb_pkg::IMFB_FLAG_RST;
      st_q.conv_flag <= imfb_pkg::IMFB_FLAG_RST;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign wb_ack_o = st_q.ack;
  assign wb_dat_o = st_q.rdata;
  // (RULE_10) Request gated by CPU enable
  assign irq_request = pend & st_q.ei;
  assign entry_busy = st_q.busy;
  assign entry_done = st_q.done;

  // (RULE_07) Flag read clears
  property p_conv_clear;
    @(posedge sys_clk) disable iff (reset)
    (rd && wb_adr_i == imfb_pkg::IMFB_CONV_FLAG_ADDR && !converter_done_event) |=> !st_q.conv_flag;
  endproperty
  a_conv_clear: assert property (p_conv_clear) else $error("converter flag not cleared by read"); // RULE_07

  // (RULE_06) Event sets flag
  property p_conv_set;
    @(posedge sys_clk) disable iff (reset)
    converter_done_event |=> st_q.conv_flag;
  endproperty
  a_conv_set: assert property (p_conv_set) else $error("converter flag not set"); // RULE_06

  // (RULE_05) Slow tick sets flag
  property p_tick_set;
    @(posedge sys_clk) disable iff (reset)
    slow_tick_event |=> st_q.tick_flag[imfb_pkg::IMFB_SLOW_BIT];
  endproperty
  a_tick_set: assert property (p_tick_set) else $error("slow tick flag not set"); // RULE_05

  // (RULE_08) Unused bits zero
  property p_unused_zero;
    @(posedge sys_clk) disable iff (reset)
    wb_ack_o |-> (wb_dat_o[31:4] == 28'h0000000);
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused read bits not zero"); // RULE_08

  // (RULE_12) Masked request
  property p_irq_gate;
    @(posedge sys_clk) disable iff (reset)
    (st_q.conv_flag && st_q.conv_en && st_q.ei) |-> irq_request;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("request missing for enabled flag"); // RULE_12

  // (RULE_10) No request without CPU enable
  property p_no_irq_di;
    @(posedge sys_clk) disable iff (reset)
    !st_q.ei |-> !irq_request;
  endproperty
  a_no_irq_di: assert property (p_no_irq_di) else $error("request while CPU enable clear"); // RULE_10

  // (RULE_11) Entry lasts twelve cycles
  property p_entry_len;
    @(posedge sys_clk) disable iff (reset)
    $rose(entry_busy) |-> ##11 entry_busy ##1 (!entry_busy && entry_done);
  endproperty
  a_entry_len: assert property (p_entry_len) else $error("entry length not twelve cycles"); // RULE_11

  // (RULE_01) Timer mask write
  property p_tick_wr;
    @(posedge sys_clk) disable iff (reset)
    (wr && wb_adr_i == imfb_pkg::IMFB_TICK_EN_ADDR) |=> (st_q.tick_en == $past(wb_dat_i[2:0]));
  endproperty
  a_tick_wr: assert property (p_tick_wr) else $error("timer mask write lost"); // RULE_01

  // (RULE_09) Reset clears state
  property p_reset_clear;
    @(posedge sys_clk)
    reset |=> (st_q.pin_en == 4'h0 && st_q.tick_flag == 3'h0 && !irq_request);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset did not clear bank"); // RULE_09

  // (RULE_02) Converter mask write
  property p_conv_wr;
    @(posedge sys_clk) disable iff (reset)
    (wr && wb_adr_i == imfb_pkg::IMFB_CONV_EN_ADDR) |=> (st_q.conv_en == $past(wb_dat_i[0]));
  endproperty
  a_conv_wr: assert property (p_conv_wr) else $error("converter mask write lost"); // RULE_02

  // (RULE_03) Per-pin mask write
  property p_pin_wr;
    @(posedge sys_clk) disable iff (reset)
    (wr && wb_adr_i == imfb_pkg::IMFB_PIN_EN_ADDR) |=> (st_q.pin_en == $past(wb_dat_i[3:0]));
  endproperty
  a_pin_wr: assert property (p_pin_wr) else $error("pin mask write lost"); // RULE_03

  // (RULE_04) Enabled pin edge sets flag
  property p_pin_set;
    @(posedge sys_clk) disable iff (reset)
    (|(pin_rise & st_q.pin_en)) |=> st_q.pin_flag;
  endproperty
  a_pin_set: assert property (p_pin_set) else $error("pin flag not set"); // RULE_04

  // (RULE_05) Mid tick sets flag
  property p_mid_set;
    @(posedge sys_clk) disable iff (reset)
    mid_tick_event |=> st_q.tick_flag[imfb_pkg::IMFB_MID_BIT];
  endproperty
  a_mid_set: assert property (p_mid_set) else $error("mid tick flag not set"); // RULE_05

  // (RULE_05) Fast tick sets flag
  property p_fast_set;
    @(posedge sys_clk) disable iff (reset)
    fast_tick_event |=> st_q.tick_flag[imfb_pkg::IMFB_FAST_BIT];
  endproperty
  a_fast_set: assert property (p_fast_set) else $error("fast tick flag not set"); // RULE_05

  // (RULE_07) Timer flag read clears
  property p_tick_clear;
    @(posedge sys_clk) disable iff (reset)
    (rd && wb_adr_i == imfb_pkg::IMFB_TICK_FLAG_ADDR && !(|tick_ev)) |=> (st_q.tick_flag == 3'h0);
  endproperty
  a_tick_clear: assert property (p_tick_clear) else $error("timer flags not cleared by read"); // RULE_07

  // (RULE_07) Pin flag read clears
  property p_pin_clear;
    @(posedge sys_clk) disable iff (reset)
    (rd && wb_adr_i == imfb_pkg::IMFB_PIN_FLAG_ADDR && !(|(pin_rise & st_q.pin_en))) |=> !st_q.pin_flag;
  endproperty
  a_pin_clear: assert property (p_pin_clear) else $error("pin flag not cleared by read"); // RULE_07

  // (RULE_08) Low lane off ignores write
  property p_sel_ignore;
    @(posedge sys_clk) disable iff (reset)
    (access && wb_we_i && !wb_sel_i[0]) |=> $stable({st_q.pin_en, st_q.tick_en, st_q.conv_en});
  endproperty
  a_sel_ignore: assert property (p_sel_ignore) else $error("masked write changed a mask"); // RULE_08

  // (RULE_08) Flag register ignores writes
  property p_flag_ro;
    @(posedge sys_clk) disable iff (reset)
    (wr && wb_adr_i == imfb_pkg::IMFB_TICK_FLAG_ADDR && !(|tick_ev)) |=> $stable(st_q.tick_flag);
  endproperty
  a_flag_ro: assert property (p_flag_ro) else $error("write changed timer flags"); // RULE_08

  // (RULE_09) Reset clears remaining state
  property p_reset_rest;
    @(posedge sys_clk)
    reset |=> (st_q.conv_en == 1'b0 && st_q.tick_en == 3'h0 && !st_q.pin_flag && !st_q.conv_flag);
  endproperty
  a_reset_rest: assert property (p_reset_rest) else $error("reset left a mask or flag set"); // RULE_09

  // (RULE_10) Entry drops CPU enable
  property p_entry_ei;
    @(posedge sys_clk) disable iff (reset)
    $rose(entry_busy) |-> !st_q.ei;
  endproperty
  a_entry_ei: assert property (p_entry_ei) else $error("CPU enable kept on entry"); // RULE_10

  // (RULE_10) Entry needs enable and request
  property p_entry_cause;
    @(posedge sys_clk) disable iff (reset)
    $rose(entry_busy) |-> ($past(st_q.ei) && $past(pend));
  endproperty
  a_entry_cause: assert property (p_entry_cause) else $error("entry without enabled request"); // RULE_10

  // (RULE_12) Timer request gate
  property p_tick_gate;
    @(posedge sys_clk) disable iff (reset)
    ((|(st_q.tick_flag & st_q.tick_en)) && st_q.ei) |-> irq_request;
  endproperty
  a_tick_gate: assert property (p_tick_gate) else $error("request missing for timer flag"); // RULE_12

  // (RULE_12) Pin request gate
  property p_pin_gate;
    @(posedge sys_clk) disable iff (reset)
    (st_q.pin_flag && (|st_q.pin_en) && st_q.ei) |-> irq_request;
  endproperty
  a_pin_gate: assert property (p_pin_gate) else $error("request missing for pin flag"); // RULE_12

  // (RULE_05) Timer flags readable
  property p_read_flags;
    @(posedge sys_clk) disable iff (reset)
    (rd && wb_adr_i == imfb_pkg::IMFB_TICK_FLAG_ADDR) |=> (wb_ack_o && wb_dat_o[2:0] == $past(st_q.tick_flag));
  endproperty
  a_read_flags: assert property (p_read_flags) else $error("timer flags read wrong"); // RULE_05

  // (RULE_11) Done follows busy only
  property p_done_pulse;
    @(posedge sys_clk) disable iff (reset)
    entry_done |-> (!entry_busy && $past(entry_busy));
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done without finished entry"); // RULE_11
endmodule : imfb_bank
`default_nettype wire

/* File: hdl/imfb_pkg.sv */
// Package for the interrupt mask and factor-flag bank
package imfb_pkg;
  // Register byte addresses on the bus
  localparam logic [7:0] IMFB_PIN_EN_ADDR = 8'hE8;
  localparam logic [7:0] IMFB_TICK_EN_ADDR = 8'hEB;
  localparam logic [7:0] IMFB_CONV_EN_ADDR = 8'hEC;
  localparam logic [7:0] IMFB_PIN_FLAG_ADDR = 8'hED;
  localparam logic [7:0] IMFB_TICK_FLAG_ADDR = 8'hEF;
  localparam logic [7:0] IMFB_CONV_FLAG_ADDR = 8'hF0;
  localparam logic [7:0] IMFB_CTRL_ADDR = 8'hF4;
  localparam logic [7:0] IMFB_ENTRY_ADDR = 8'hF8;
  // Field positions
  localparam int IMFB_FAST_BIT = 0;
  localparam int IMFB_MID_BIT = 1;
  localparam int IMFB_SLOW_BIT = 2;
  localparam int IMFB_FLAG_BIT = 0;
  localparam int IMFB_EI_BIT = 0;
  // Reset values
  localparam logic [3:0] IMFB_PIN_EN_RST = 4'h0;
  localparam logic [2:0] IMFB_TICK_EN_RST = 3'h0;
  localparam logic IMFB_CONV_EN_RST = 1'b0;
  localparam logic [2:0] IMFB_TICK_FLAG_RST = 3'h0;
  localparam logic IMFB_FLAG_RST = 1'b0;
  // Interrupt entry length in system clock cycles
  localparam int IMFB_ENTRY_CYCLES = 12;
endpackage : imfb_pkg

/* File: hdl/imfb_sync.sv */
// Two-flop synchroniser with rising-edge pulse output
`timescale 1ns/10ps
`default_nettype none
module imfb_sync #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Asynchronous in, synchronous out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] level_out,
  output logic [WIDTH-1:0] rise_out
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
    logic [WIDTH-1:0] last;
  } imfb_sync_s;
  imfb_sync_s st_q;
  imfb_sync_s st_d;

  always_comb
  begin
    st_d = st_q;
    st_d.meta = async_in;
    st_d.sync = st_q.meta;
    st_d.last = st_q.sync;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Edge taken from the second and third flops only
  assign level_out = st_q.sync;
  assign rise_out = st_q.sync & ~st_q.last;
endmodule : imfb_sync
`default_nettype wire

/* File: dv/imfb_cpu_model.sv */
// CPU core bus master model for the interrupt bank
`timescale 1ns/10ps
`default_nettype none
module imfb_cpu_model (
  // Clock
  input wire logic sys_clk,
  // Wishbone master side
  output logic wb_cyc_o,
  output logic wb_stb_o,
  output logic wb_we_o,
  output logic [7:0] wb_adr_o,
  output logic [3:0] wb_sel_o,
  output logic [31:0] wb_dat_o,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_i
);
  initial
  begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o = 1'b0;
    wb_adr_o = 8'h00;
    wb_sel_o = 4'hF;
    wb_dat_o = 32'h0;
  end
  // No latency is assumed; only the bench watchdog ends a stuck wait
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge sys_clk);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o <= we;
    wb_adr_o <= adr;
    wb_dat_o <= wd;
    do @(posedge sys_clk);
    while (wb_ack_i !== 1'b1);
    rd = wb_dat_i;
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_we_o <= 1'b0;
    // Released data must not look like a held value
    wb_dat_o <= ~wd;
  endtask
endmodule // imfb_cpu_model
`default_nettype wire

/* File: dv/test_interrupt_mask_flag_bank.sv */
// Self-checking bench for the interrupt mask and flag bank
`timescale 1ns/10ps
`default_nettype none
module test_interrupt_mask_flag_bank;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic cyc, stb, we, ack, irq, busy, done;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  logic [3:0] input_pins = 4'h0;
  logic slow = 1'b0, mid = 1'b0, fast = 1'b0, conv = 1'b0;
  int err_count = 0;
  int tests_run = 0;
  always #10 sys_clk = ~sys_clk;
  imfb_cpu_model cpu (.sys_clk(sys_clk), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr),
    .wb_sel_o(sel), .wb_dat_o(wdat), .wb_dat_i(rdat), .wb_ack_i(ack));
  imfb_bank DUT (.sys_clk(sys_clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .input_pins(input_pins), .slow_tick_event(slow), .mid_tick_event(mid), .fast_tick_event(fast),
    .converter_done_event(conv), .irq_request(irq), .entry_busy(busy), .entry_done(done));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    cpu.xfer(1'b0, a, 32'h0, d);
    chk(d, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] d;
    cpu.xfer(1'b1, a, v, d);
  endtask
  // Order is slow, mid, fast, converter
  task automatic pulse(input logic [3:0] v);
    @(posedge sys_clk);
    {slow, mid, fast, conv} <= v;
    @(posedge sys_clk);
    {slow, mid, fast, conv} <= 4'h0;
    repeat (2) @(posedge sys_clk);
  endtask
  logic [7:0] addrs [6] = '{8'hE8, 8'hEB, 8'hEC, 8'hED, 8'hEF, 8'hF0};
  task automatic t_reset();
    foreach (addrs[i]) rd(addrs[i], 32'h0);
    rd(8'hF4, 32'h0);
    rd(8'hF8, 32'h0);
    rd(8'h80, 32'h0);
  endtask
  // Mid-run reset with masks and a flag set
  task automatic t_rerst();
    pulse(4'h8);
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    t_reset();
  endtask
  task automatic t_masks();
    wr(8'hE8, 32'hFFFFFFFF);
    rd(8'hE8, 32'hF);
    wr(8'hEB, 32'hFFFFFFF5);
    rd(8'hEB, 32'h5);
    wr(8'hEB, 32'h2);
    rd(8'hEB, 32'h2);
    wr(8'hEC, 32'hF);
    rd(8'hEC, 32'h1);
    wr(8'hEF, 32'hF);
    rd(8'hEF, 32'h0);
  endtask
  task automatic t_flags();
    pulse(4'h8);
    rd(8'hEF, 32'h4);
    pulse(4'h4);
    rd(8'hEF, 32'h2);
    pulse(4'h2);
    rd(8'hEF, 32'h1);
    rd(8'hEF, 32'h0);
    pulse(4'h1);
    rd(8'hF0, 32'h1);
    rd(8'hF0, 32'h0);
  endtask
  task automatic t_irq();
    int n;
    wr(8'hEB, 32'h1);
    pulse(4'h2);
    chk(irq, 1'b0);
    wr(8'hF4, 32'h1);
    chk(irq, 1'b1);
    n = 0;
    while (busy !== 1'b1 && n < 20)
    begin
      @(posedge sys_clk);
      n++;
    end
    n = 0;
    while (busy === 1'b1 && n < 40)
    begin
      n++;
      @(posedge sys_clk);
    end
    chk(n, 12);
    chk(done, 1'b1);
    chk(irq, 1'b0);
    rd(8'hF4, 32'h0);
    rd(8'hEF, 32'h1);
    wr(8'hEB, 32'h6);
    wr(8'hF4, 32'h1);
    pulse(4'h2);
    chk(irq, 1'b0);
    rd(8'hEF, 32'h1);
  endtask
  task automatic t_pins();
    wr(8'hE8, 32'h1);
    @(posedge sys_clk);
    input_pins <= 4'h2;
    repeat (6) @(posedge sys_clk);
    rd(8'hED, 32'h0);
    input_pins <= 4'h3;
    repeat (6) @(posedge sys_clk);
    rd(8'hED, 32'h1);
    rd(8'hED, 32'h0);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    t_reset();
    t_masks();
    t_rerst();
    t_flags();
    t_irq();
    t_pins();
    end_sim();
  end
  // Whole run needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    err_count++;
    end_sim();
  end
endmodule // test_interrupt_mask_flag_bank
`default_nettype wire
